// ### core/hrc_pkg.sv
/*
 * Constants, register map and carrier types for the hub release number and
 * first configuration byte register bank.
 * Assumes a single 50 MHz core clock and an SMBus-style two-wire configuration
 * port whose pins are sampled by that clock.
 */
// Summary of operation
// - Release number is 16-bit BCD; low byte at 04h, high byte at 05h, read/write.
// - Config byte one bit 7 picks power source: 0 bus, 1 self; default 0.
// - With dynamic power on, power source follows the local supply sense pin.
// - Bit 7 of config byte two at 07h enables dynamic power switching.
// - Config byte one bit 5 set forces full-speed-only attach; default 0.
// - A host forcing single-translator mode overrides the per-port selection.
package hrc_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] OFS_RELEASE_NUMBER_LOW = 8'h04;
   localparam logic [7:0] OFS_RELEASE_NUMBER_HIGH = 8'h05;
   localparam logic [7:0] OFS_HUB_CONFIG_ONE = 8'h06;
   localparam logic [7:0] OFS_HUB_CONFIG_TWO = 8'h07;

   // ****************************************************************
   // Field positions, masks and reset values
   // ****************************************************************
   localparam int POWER_SOURCE_SELECT_BIT = 7;
   localparam int HUB_CONFIG_ONE_RESERVED_BIT = 6;
   localparam int FAST_ATTACH_INHIBIT_BIT = 5;
   localparam int PER_PORT_TRANSLATOR_BIT = 4;
   localparam int DYNAMIC_POWER_BIT = 7;
   localparam logic [7:0] HUB_CONFIG_ONE_WRITE_MASK = 8'hbf;
   localparam logic [7:0] RELEASE_BYTE_RESET = 8'h00;
   localparam logic [7:0] HUB_CONFIG_ONE_RESET = 8'h00;
   localparam logic DYNAMIC_POWER_RESET = 1'b0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ****************************************************************
   // Two-wire port
   // ****************************************************************
   // Slave address value is arbitrary
   localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2c;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int SYNC_WIDTH = 3;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_RX_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_TX_ACK = 5'h10
   } hrc_state_type;

   typedef enum logic [2:0] {
      PH_ADDR = 3'h1,
      PH_OFFSET = 3'h2,
      PH_DATA = 3'h4
   } hrc_phase_type;

   typedef struct packed {
      logic self_powered;
      logic fast_attach_inhibit;
      logic per_port_translator_active;
      logic dynamic_power_enable;
   } hrc_status_type;

   localparam hrc_status_type STATUS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// ### core/hrc_sync.sv
/*
 * Two-flip-flop synchroniser for a group of asynchronous input levels.
 * Assumes the reset given is already synchronous to clk on release.
 */
`timescale 1ns/1ps
module hrc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // Only the second stage is visible to the outside
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q[i] <= 1'b0;
            sync_out[i] <= 1'b0;
         end else begin
            meta_q[i] <= async_in[i];
            sync_out[i] <= meta_q[i];
         end
      end
   end
endmodule // hrc_sync

// ### core/hrc_regs_top.sv
/*
 * Release number and first configuration byte register bank with its
 * two-wire configuration slave and the derived hub mode outputs.
 * Assumes scl/sda come from an external open-drain bus (sda pulled up outside)
 * and host_force_single comes from hub core logic on the same clock.
 */
`timescale 1ns/1ps
module hrc_regs_top #(
   parameter logic [6:0] SLAVE_ADDR = hrc_pkg::SLAVE_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Two-wire configuration pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Hub core side
   input wire logic local_supply_sense,
   input wire logic host_force_single,
   output logic [15:0] release_number,
   output hrc_pkg::hrc_status_type hub_status
);

   // ****************************************************************
   // Reset release and input synchronisation
   // ****************************************************************
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   logic scl_s;
   logic sda_s;
   logic sense_s;

   hrc_sync #(.WIDTH(hrc_pkg::SYNC_WIDTH)) i_hrc_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({scl_i, sda_i, local_supply_sense}),
      .sync_out({scl_s, sda_s, sense_s})
   );

   // ****************************************************************
   // State
   // ****************************************************************
   hrc_pkg::hrc_state_type state_q, state_d;
   hrc_pkg::hrc_phase_type phase_q, phase_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic sda_oe_q, sda_oe_d;
   logic scl_p_q;
   logic sda_p_q;
   logic [7:0] rel_lo_q, rel_lo_d;
   logic [7:0] rel_hi_q, rel_hi_d;
   logic [7:0] hub_config_one_q, hub_config_one_d;
   logic dyn_q, dyn_d;
   hrc_pkg::hrc_status_type status_q, status_d;

   logic start_c;
   logic stop_c;
   logic rise_c;
   logic fall_c;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_byte;

   // Unmapped offsets read as zero so the pointer may roam freely
   function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [7:0] c1, input logic dy);
      logic [7:0] r;
      r = hrc_pkg::READ_UNMAPPED;
      if (addr == hrc_pkg::OFS_RELEASE_NUMBER_LOW) begin
         r = lo;
      end else if (addr == hrc_pkg::OFS_RELEASE_NUMBER_HIGH) begin
         r = hi;
      end else if (addr == hrc_pkg::OFS_HUB_CONFIG_ONE) begin
         r = c1 & hrc_pkg::HUB_CONFIG_ONE_WRITE_MASK;
      end else if (addr == hrc_pkg::OFS_HUB_CONFIG_TWO) begin
         r[hrc_pkg::DYNAMIC_POWER_BIT] = dy;
      end
      return r;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      tx_d = tx_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      sda_oe_d = sda_oe_q;
      rel_lo_d = rel_lo_q;
      rel_hi_d = rel_hi_q;
      hub_config_one_d = hub_config_one_q;
      dyn_d = dyn_q;
      wr_en = 1'b0;
      wr_addr = ptr_q;
      wr_data = sh_q;
      rd_byte = reg_read(ptr_q, rel_lo_q, rel_hi_q, hub_config_one_q, dyn_q);
      start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
      stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
      rise_c = scl_s & ~scl_p_q;
      fall_c = ~scl_s & scl_p_q;

      if (stop_c) begin
         state_d = hrc_pkg::ST_IDLE;
         sda_oe_d = 1'b0;
      end else if (start_c) begin
         // Repeated start keeps the pointer for a following read
         state_d = hrc_pkg::ST_RX;
         phase_d = hrc_pkg::PH_ADDR;
         cnt_d = '0;
         sda_oe_d = 1'b0;
      end else begin
         case (state_q)
            hrc_pkg::ST_RX: begin
               if (rise_c) begin
                  sh_d = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end else if (fall_c && cnt_q == hrc_pkg::BITS_PER_BYTE) begin
                  cnt_d = '0;
                  if (phase_q == hrc_pkg::PH_ADDR) begin
                     if (sh_q[7:1] == SLAVE_ADDR) begin
                        rw_d = sh_q[0];
                        sda_oe_d = 1'b1;
                        state_d = hrc_pkg::ST_RX_ACK;
                     end else begin
                        state_d = hrc_pkg::ST_IDLE;
                     end
                  end else begin
                     sda_oe_d = 1'b1;
                     state_d = hrc_pkg::ST_RX_ACK;
                     if (phase_q == hrc_pkg::PH_OFFSET) begin
                        ptr_d = sh_q;
                     end else begin
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                     end
                  end
               end
            end
            hrc_pkg::ST_RX_ACK: begin
               if (fall_c) begin
                  if (phase_q == hrc_pkg::PH_ADDR && rw_q) begin
                     sda_oe_d = ~rd_byte[7];
                     tx_d = {rd_byte[6:0], 1'b0};
                     ptr_d = ptr_q + 8'h01;
                     state_d = hrc_pkg::ST_TX;
                  end else begin
                     sda_oe_d = 1'b0;
                     state_d = hrc_pkg::ST_RX;
                     if (phase_q == hrc_pkg::PH_ADDR) begin
                        phase_d = hrc_pkg::PH_OFFSET;
                     end else begin
                        phase_d = hrc_pkg::PH_DATA;
                     end
                  end
               end
            end
            hrc_pkg::ST_TX: begin
               if (rise_c) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (fall_c) begin
                  if (cnt_q == hrc_pkg::BITS_PER_BYTE) begin
                     sda_oe_d = 1'b0;
                     state_d = hrc_pkg::ST_TX_ACK;
                  end else begin
                     sda_oe_d = ~tx_q[7];
                     tx_d = {tx_q[6:0], 1'b0};
                  end
               end
            end
            hrc_pkg::ST_TX_ACK: begin
               if (rise_c) begin
                  if (sda_s) begin
                     state_d = hrc_pkg::ST_IDLE;
                  end else begin
                     tx_d = rd_byte;
                     ptr_d = ptr_q + 8'h01;
                     cnt_d = '0;
                     state_d = hrc_pkg::ST_TX;
                  end
               end
            end
            default: begin
               state_d = hrc_pkg::ST_IDLE;
            end
         endcase
      end

      if (wr_en) begin
         if (wr_addr == hrc_pkg::OFS_RELEASE_NUMBER_LOW) begin
            rel_lo_d = wr_data;
         end else if (wr_addr == hrc_pkg::OFS_RELEASE_NUMBER_HIGH) begin
            rel_hi_d = wr_data;
         end else if (wr_addr == hrc_pkg::OFS_HUB_CONFIG_ONE) begin
            hub_config_one_d = wr_data & hrc_pkg::HUB_CONFIG_ONE_WRITE_MASK;
         end else if (wr_addr == hrc_pkg::OFS_HUB_CONFIG_TWO) begin
            dyn_d = wr_data[hrc_pkg::DYNAMIC_POWER_BIT];
         end
      end

      // Dynamic mode ignores the select bit and trusts the supply sense
      status_d.self_powered = dyn_q ? sense_s : hub_config_one_q[hrc_pkg::POWER_SOURCE_SELECT_BIT];
      status_d.fast_attach_inhibit = hub_config_one_q[hrc_pkg::FAST_ATTACH_INHIBIT_BIT];
      status_d.per_port_translator_active =
         hub_config_one_q[hrc_pkg::PER_PORT_TRANSLATOR_BIT] & ~host_force_single;
      status_d.dynamic_power_enable = dyn_q;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= hrc_pkg::ST_IDLE;
         phase_q <= hrc_pkg::PH_ADDR;
         cnt_q <= '0;
         sh_q <= '0;
         tx_q <= '0;
         ptr_q <= '0;
         rw_q <= 1'b0;
         sda_oe_q <= 1'b0;
         sda_o <= 1'b0;
         scl_p_q <= 1'b0;
         sda_p_q <= 1'b0;
         rel_lo_q <= hrc_pkg::RELEASE_BYTE_RESET;
         rel_hi_q <= hrc_pkg::RELEASE_BYTE_RESET;
         hub_config_one_q <= hrc_pkg::HUB_CONFIG_ONE_RESET;
         dyn_q <= hrc_pkg::DYNAMIC_POWER_RESET;
         status_q <= hrc_pkg::STATUS_RESET;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         sda_oe_q <= sda_oe_d;
         sda_o <= 1'b0;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
         rel_lo_q <= rel_lo_d;
         rel_hi_q <= rel_hi_d;
         hub_config_one_q <= hub_config_one_d;
         dyn_q <= dyn_d;
         status_q <= status_d;
      end
   end

   assign sda_oe = sda_oe_q;
   assign release_number = {rel_hi_q, rel_lo_q};
   assign hub_status = status_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_REL_LOW_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && wr_addr == hrc_pkg::OFS_RELEASE_NUMBER_LOW |=> ##1 release_number[7:0] == $past(wr_data, 2))
      else $error("release low byte not stored");
   AST_REL_HIGH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr_en && wr_addr == hrc_pkg::OFS_RELEASE_NUMBER_HIGH) |=> $stable(release_number[15:8]))
      else $error("release high byte changed without a write");
   AST_POWER_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
      !dyn_q |=> hub_status.self_powered == $past(hub_config_one_q[hrc_pkg::POWER_SOURCE_SELECT_BIT]))
      else $error("self powered does not follow select bit");
   AST_DYNAMIC_SENSE: assert property (@(posedge clk) disable iff (!rst_n)
      dyn_q [*2] |-> hub_status.self_powered == $past(sense_s))
      else $error("self powered does not follow supply sense");
   AST_DYNAMIC_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      wr_en && wr_addr == hrc_pkg::OFS_HUB_CONFIG_TWO |=> ##1
         hub_status.dynamic_power_enable == $past(wr_data[hrc_pkg::DYNAMIC_POWER_BIT], 2))
      else $error("dynamic enable not applied");
   AST_FAST_INHIBIT: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(hub_config_one_q[hrc_pkg::FAST_ATTACH_INHIBIT_BIT]) |=> hub_status.fast_attach_inhibit)
      else $error("full speed only not applied");
   AST_PER_PORT_TT: assert property (@(posedge clk) disable iff (!rst_n)
      hub_config_one_q[hrc_pkg::PER_PORT_TRANSLATOR_BIT] && !host_force_single |=> hub_status.per_port_translator_active)
      else $error("per port translators not active");
   AST_HOST_FORCE: assert property (@(posedge clk) disable iff (!rst_n)
      host_force_single |=> !hub_status.per_port_translator_active)
      else $error("host single translator override ignored");
   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
      ptr_q == hrc_pkg::OFS_HUB_CONFIG_ONE |->
         !rd_byte[hrc_pkg::HUB_CONFIG_ONE_RESERVED_BIT] && !hub_config_one_q[hrc_pkg::HUB_CONFIG_ONE_RESERVED_BIT])
      else $error("reserved bit reads one");

endmodule // hrc_regs_top

// ### tb/hrc_host_model.sv
/*
 * Behavioural two-wire configuration master that loads and reads back the
 * hub release number and configuration bytes.
 * Assumes the bench resolves sda as an open-drain wire with a pull-up and
 * that all pin changes happen at the falling edge of clk.
 */
`timescale 1ns/1ps
module hrc_host_model #(
   parameter logic [6:0] ADDR = hrc_pkg::SLAVE_ADDR_DEFAULT
) (
   // Clock
   input wire logic clk,
   // Bus wires
   input wire logic sda,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // ****************************************************************
   // Bit level
   // ****************************************************************
   task automatic hold();
      repeat (10) @(negedge clk);
   endtask

   // Data moves two cycles after the scl fall so the slave never sees it race the clock
   task automatic clock_bit(input logic pull, output logic seen);
      repeat (2) @(negedge clk);
      sda_pull = pull;
      hold();
      scl = 1'b1;
      repeat (5) @(negedge clk);
      seen = sda;
      repeat (5) @(negedge clk);
      scl = 1'b0;
   endtask

   task automatic start();
      repeat (2) @(negedge clk);
      sda_pull = 1'b0;
      hold();
      scl = 1'b1;
      hold();
      sda_pull = 1'b1;
      hold();
      scl = 1'b0;
   endtask

   task automatic stop();
      repeat (2) @(negedge clk);
      sda_pull = 1'b1;
      hold();
      scl = 1'b1;
      hold();
      sda_pull = 1'b0;
      hold();
   endtask

   // ****************************************************************
   // Byte level
   // ****************************************************************
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(~b[i], s);
      end
      clock_bit(1'b0, s);
      ack = ~s;
   endtask

   task automatic get_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b0, s);
         b[i] = s;
      end
      clock_bit(more, s);
   endtask

   // Burst write through the auto-incrementing pointer
   task automatic write_regs(input logic [7:0] ofs, input logic [7:0] d [$], output logic ok);
      logic a;
      start();
      put_byte({ADDR, 1'b0}, ok);
      put_byte(ofs, a);
      ok = ok & a;
      foreach (d[i]) begin
         put_byte(d[i], a);
         ok = ok & a;
      end
      stop();
   endtask

   task automatic read_regs(input logic [7:0] ofs, input int n, output logic [7:0] d [$]);
      logic a;
      logic [7:0] b;
      d = {};
      start();
      put_byte({ADDR, 1'b0}, a);
      put_byte(ofs, a);
      start();
      put_byte({ADDR, 1'b1}, a);
      for (int i = 0; i < n; i++) begin
         get_byte(i != n - 1, b);
         d.push_back(b);
      end
      stop();
   endtask
endmodule // hrc_host_model

// ### tb/tb_hrc_regs_top.sv
/*
 * Self-checking bench for the release number and configuration byte bank.
 * Assumes the host model drives the two-wire pins and sda has a pull-up.
 */
`timescale 1ns/1ps
module tb_hrc_regs_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic sense = 1'b0;
   logic force_single = 1'b0;
   logic scl, pull, sda, sda_o, sda_oe, ok;
   logic [15:0] rel;
   hrc_pkg::hrc_status_type st;
   logic [7:0] rd [$];
   logic [7:0] lo, hi, c1, c2;
   logic [31:0] rng = 32'h580a;
   int miscompares = 0;
   int n_compared = 0;

   always #10 clk = ~clk;
   assign sda = (sda_oe | pull) ? 1'b0 : 1'b1;

   hrc_regs_top i_hrc_regs_top (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .local_supply_sense(sense), .host_force_single(force_single), .release_number(rel),
      .hub_status(st));
   hrc_host_model i_hrc_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   function automatic logic [7:0] bcd(input logic [31:0] r);
      return {4'(r[7:4] % 4'ha), 4'(r[11:8] % 4'ha)};
   endfunction

   function automatic hrc_pkg::hrc_status_type exp_status(input logic [7:0] c, input logic dy, input logic s,
      input logic f);
      return '{dy ? s : c[7], c[5], c[4] & ~f, dy};
   endfunction

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      // About twice the expected run length, well under the cycle budget
      #1_200_000;
      miscompares++;
      wrap_up();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      repeat (8) @(negedge clk);
      check("release reset", 16'h0000, rel);
      check("status reset", 16'h0000, 16'(st));
      check("sda out level", 16'h0000, 16'(sda_o));
      i_hrc_host_model.read_regs(8'h04, 3, rd);
      foreach (rd[i]) check("reset readback", 16'h0000, 16'(rd[i]));

      for (int k = 0; k < 4; k++) begin
         lo = (k == 0) ? 8'h99 : bcd(rnd());
         hi = (k == 0) ? 8'h99 : bcd(rnd());
         i_hrc_host_model.write_regs(8'h04, '{lo, hi}, ok);
         check("release write ack", 16'h0001, 16'(ok));
         check("release number", {hi, lo}, rel);
         i_hrc_host_model.read_regs(8'h04, 2, rd);
         check("release readback", {hi, lo}, {rd[1], rd[0]});
      end

      // Shared translator forced by the host on the first pass and released on the second
      for (int k = 0; k < 8; k++) begin
         c1 = 8'(rnd());
         c2 = 8'(rnd());
         if (k < 2) c1[4] = 1'b1;
         force_single = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : 1'(rnd());
         sense = 1'(rnd());
         i_hrc_host_model.write_regs(8'h06, '{c1, c2}, ok);
         repeat (6) @(negedge clk);
         check("status", 16'(exp_status(c1, c2[7], sense, force_single)), 16'(st));
         i_hrc_host_model.read_regs(8'h06, 2, rd);
         check("config one readback", 16'(c1 & 8'hbf), 16'(rd[0]));
         check("config two readback", 16'({c2[7], 7'h00}), 16'(rd[1]));
         sense = ~sense;
         repeat (8) @(negedge clk);
         check("status sense", 16'(exp_status(c1, c2[7], sense, force_single)), 16'(st));
      end

      i_hrc_host_model.start();
      i_hrc_host_model.put_byte({7'h2d, 1'b0}, ok);
      i_hrc_host_model.stop();
      check("foreign address ack", 16'h0000, 16'(ok));
      i_hrc_host_model.write_regs(8'h20, '{8'h5a}, ok);
      check("unmapped write ack", 16'h0001, 16'(ok));
      i_hrc_host_model.read_regs(8'h20, 1, rd);
      check("unmapped read", 16'h0000, 16'(rd[0]));
      wrap_up();
   end
endmodule // tb_hrc_regs_top
